// file: verilog/dbio_pkg.sv
// Contract
// - Direction bit 1 makes its pin an output, 0 an input, per bit.
// - Input pins pass two flip-flops before loading the input register bit.
// - Output pins are driven straight from the stored output register bit, except first port bits and second port line 1 with their special bit set.
// - The unused register bit of a pin keeps its value and affects nothing.
// - Software writes to input bits of input pins are overwritten next cycle.
// - Input bits of output pins do not sample and keep the written value.
// - Output register reads return the stored value, not the pin level.
// - Output-configured pins have their Schmitt input path disabled.
// - Output register writes take effect on a rising clock edge.
// - First port output bits with special bit set drive open-drain.
// - Second port has five independent bidirectional Schmitt lines.
// - Second port special map: wake, timer out, irq1, cmp ref, cmp signal.
// - Full reset leaves both output registers unchanged.
// - Full reset clears both direction registers, all pins become inputs.
// - After reset input registers take the current synchronized pin sample.
// - Full reset clears both special-function registers.
// - Wake events and watchdog timeouts do not touch port registers.
// - Comparator is enabled by special bits 3 and 4 of second port.
// - With comparator on, input bit 4 is comparator, bit 3 the ref pin.
// - With comparator selected, bit 4 interrupts come from its result.
// - Comparator result is high when signal exceeds reference.
// - Timer0 end-of-count toggles the flip-flop driving line 1 output.
package dbio_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int PA_W   = 8;
    localparam int PB_W   = 5;
    localparam int SYNC_W = PA_W + PB_W + 1;
    localparam int ADR_W  = 12;
    localparam int DAT_W  = 32;

    // ------------------------------------------------------------
    // Register indexes; byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_PA_IN  = 10'h0d0;
    localparam logic [9:0] IDX_PA_OUT = 10'h0d1;
    localparam logic [9:0] IDX_PA_DIR = 10'h0d2;
    localparam logic [9:0] IDX_PA_SFR = 10'h0d3;
    localparam logic [9:0] IDX_PB_IN  = 10'h0d4;
    localparam logic [9:0] IDX_PB_OUT = 10'h0d5;
    localparam logic [9:0] IDX_PB_DIR = 10'h0d6;
    localparam logic [9:0] IDX_PB_SFR = 10'h0d7;

    // ------------------------------------------------------------
    // Second port special-function bit positions
    // ------------------------------------------------------------
    localparam int PB_WAKE = 0;
    localparam int PB_TOUT = 1;
    localparam int PB_IRQ1 = 2;
    localparam int PB_REF  = 3;
    localparam int PB_SIG  = 4;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [PA_W-1:0] PA_DIR_RST = 8'h00;
    localparam logic [PA_W-1:0] PA_SFR_RST = 8'h00;
    localparam logic [PB_W-1:0] PB_DIR_RST = 5'h00;
    localparam logic [PB_W-1:0] PB_SFR_RST = 5'h00;
    localparam logic            TOUT_RST   = 1'b0;

    // Register selected by the bus: hit flag and local index
    typedef struct packed {
        logic       hit;
        logic [2:0] idx;
    } dbio_sel_t;

endpackage

// file: verilog/dbio_sync_if.sv
`timescale 1ns/1ps
`default_nettype none
interface dbio_sync_if import dbio_pkg::*;;
    logic [SYNC_W-1:0] raw;
    logic [SYNC_W-1:0] synced;
    modport src  (output raw, input synced);
    modport sync (input raw, output synced);
endinterface
`default_nettype wire

// file: verilog/dbio_sync.sv
`timescale 1ns/1ps
`default_nettype none
module dbio_sync import dbio_pkg::*; (
    input  wire logic  clk_i,
    dbio_sync_if.sync  bus
);

    typedef struct packed {
        logic [SYNC_W-1:0] stage1;
        logic [SYNC_W-1:0] stage2;
    } dbio_sync_t;

    dbio_sync_t s;
    dbio_sync_t next_s;

    // No reset: the sample must stay live through reset
    always_comb begin
        next_s.stage1 = bus.raw;
        next_s.stage2 = s.stage1;
    end

    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    assign bus.synced = s.stage2;

endmodule
`default_nettype wire

// file: verilog/dbio_top.sv
// Chosen here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none
module dbio_top import dbio_pkg::*; (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    input  wire logic             we_i,
    input  wire logic [ADR_W-1:0] adr_i,
    input  wire logic [DAT_W-1:0] dat_i,
    input  wire logic [3:0]       sel_i,
    output logic      [DAT_W-1:0] dat_o,
    output logic                  ack_o,
    input  wire logic [PA_W-1:0]  pa_pin_i,
    output logic      [PA_W-1:0]  pa_pin_o,
    output logic      [PA_W-1:0]  pa_pin_oe_o,
    output logic      [PA_W-1:0]  pa_schmitt_en_o,
    input  wire logic [PB_W-1:0]  pb_pin_i,
    output logic      [PB_W-1:0]  pb_pin_o,
    output logic      [PB_W-1:0]  pb_pin_oe_o,
    output logic      [PB_W-1:0]  pb_schmitt_en_o,
    input  wire logic             cmp_result_i,
    output logic                  cmp_enable_o,
    input  wire logic             t0_end_count_i,
    output logic                  stop_wake_event_o,
    output logic                  ext_irq1_o,
    output logic                  ext_irq_b4_o
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [PA_W-1:0]  pa_in;
        logic [PA_W-1:0]  pa_out;
        logic [PA_W-1:0]  pa_dir;
        logic [PA_W-1:0]  pa_sfr;
        logic [PB_W-1:0]  pb_in;
        logic [PB_W-1:0]  pb_out;
        logic [PB_W-1:0]  pb_dir;
        logic [PB_W-1:0]  pb_sfr;
        logic             tout;
        logic             ack;
        logic [DAT_W-1:0] dat;
        logic [PA_W-1:0]  pa_drv;
        logic [PA_W-1:0]  pa_oe;
        logic [PA_W-1:0]  pa_sch;
        logic [PB_W-1:0]  pb_drv;
        logic [PB_W-1:0]  pb_oe;
        logic [PB_W-1:0]  pb_sch;
        logic             cmp_en;
        logic             wake;
        logic             irq1;
        logic             irq_b4;
    } dbio_state_t;

    dbio_state_t s;
    dbio_state_t next_s;

    // ------------------------------------------------------------
    // Input synchronizer
    // ------------------------------------------------------------
    dbio_sync_if sif ();

    assign sif.raw = {cmp_result_i, pb_pin_i, pa_pin_i};

    dbio_sync u_sync (
        .clk_i (clk_i),
        .bus   (sif)
    );

    logic [PA_W-1:0] pa_smp;
    logic [PB_W-1:0] pb_smp;
    logic            cmp_smp;

    assign pa_smp  = sif.synced[PA_W-1:0];
    assign pb_smp  = sif.synced[PA_W+PB_W-1:PA_W];
    assign cmp_smp = sif.synced[SYNC_W-1];

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    function automatic dbio_sel_t dbio_decode(input logic [ADR_W-1:0] adr);
        dbio_sel_t r;
        r.hit = (adr[1:0] == 2'h0)
              && (adr[ADR_W-1:2] >= IDX_PA_IN)
              && (adr[ADR_W-1:2] <= IDX_PB_SFR);
        r.idx = 3'(adr[ADR_W-1:2] - IDX_PA_IN);
        return r;
    endfunction

    function automatic logic [DAT_W-1:0] dbio_read(input dbio_state_t st,
                                                   input dbio_sel_t   sl);
        logic [DAT_W-1:0] d;
        d = '0;
        if (sl.hit) begin
            unique case (sl.idx)
                3'h0: d[PA_W-1:0] = st.pa_in;
                3'h1: d[PA_W-1:0] = st.pa_out;
                3'h2: d[PA_W-1:0] = st.pa_dir;
                3'h3: d[PA_W-1:0] = st.pa_sfr;
                3'h4: d[PB_W-1:0] = st.pb_in;
                3'h5: d[PB_W-1:0] = st.pb_out;
                3'h6: d[PB_W-1:0] = st.pb_dir;
                3'h7: d[PB_W-1:0] = st.pb_sfr;
            endcase
        end
        return d;
    endfunction

    dbio_sel_t bus_sel;
    logic      bus_req;
    logic      bus_wr;
    logic      cmp_on;

    assign bus_sel = dbio_decode(adr_i);
    assign bus_req = cyc_i & stb_i;
    assign bus_wr  = bus_req & s.ack & we_i & sel_i[0];
    assign cmp_on  = s.pb_sfr[PB_REF] & s.pb_sfr[PB_SIG];

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        logic [PB_W-1:0] pb_src;
        logic [PB_W-1:0] pb_val;
        logic            cmp_next;
        pb_src   = pb_smp;
        pb_val   = '0;
        cmp_next = 1'b0;
        next_s   = s;

        // Input bits follow the sample, output pins keep their bit
        // Each of the five second-port lines is handled bit by bit
        if (cmp_on) begin
            pb_src[PB_SIG] = cmp_smp;
        end
        next_s.pa_in = (s.pa_dir & s.pa_in) | (~s.pa_dir & pa_smp);
        next_s.pb_in = (s.pb_dir & s.pb_in) | (~s.pb_dir & pb_src);

        // Timer0 toggle flip-flop
        if (t0_end_count_i && s.pb_sfr[PB_TOUT] && s.pb_dir[PB_TOUT]) begin
            next_s.tout = ~s.tout;
        end

        // Wishbone: one wait state, ack for one cycle
        next_s.ack = bus_req & ~s.ack;
        next_s.dat = '0;
        if (bus_req && !s.ack) begin
            next_s.dat = dbio_read(s, bus_sel);
        end

        // Writes land on the edge that samples ack
        if (bus_wr && bus_sel.hit) begin
            unique case (bus_sel.idx)
                3'h0: next_s.pa_in  = dat_i[PA_W-1:0];
                3'h1: next_s.pa_out = dat_i[PA_W-1:0];
                3'h2: next_s.pa_dir = dat_i[PA_W-1:0];
                3'h3: next_s.pa_sfr = dat_i[PA_W-1:0];
                3'h4: next_s.pb_in  = dat_i[PB_W-1:0];
                3'h5: next_s.pb_out = dat_i[PB_W-1:0];
                3'h6: next_s.pb_dir = dat_i[PB_W-1:0];
                3'h7: next_s.pb_sfr = dat_i[PB_W-1:0];
            endcase
        end

        // Full reset; output registers are left alone
        // Only rst_i touches control state; no wake or watchdog
        if (rst_i) begin
            next_s.pa_dir = PA_DIR_RST;
            next_s.pb_dir = PB_DIR_RST;
            next_s.pa_sfr = PA_SFR_RST;
            next_s.pb_sfr = PB_SFR_RST;
            next_s.pa_in  = pa_smp;
            next_s.pb_in  = pb_smp;
            next_s.tout   = TOUT_RST;
            next_s.ack    = 1'b0;
            next_s.dat    = '0;
        end

        // Pin drivers from the registers as they will stand
        next_s.pa_drv = next_s.pa_out & next_s.pa_dir & ~next_s.pa_sfr;
        next_s.pa_oe  = next_s.pa_dir
                      & ~(next_s.pa_sfr & next_s.pa_out);
        next_s.pa_sch = ~next_s.pa_dir;
        pb_val = next_s.pb_out;
        if (next_s.pb_sfr[PB_TOUT]) begin
            pb_val[PB_TOUT] = next_s.tout;
        end
        next_s.pb_drv = pb_val & next_s.pb_dir;
        next_s.pb_oe  = next_s.pb_dir;
        next_s.pb_sch = ~next_s.pb_dir;

        // Special-function events, gated by their enables
        cmp_next       = next_s.pb_sfr[PB_REF] & next_s.pb_sfr[PB_SIG];
        next_s.cmp_en  = cmp_next;
        next_s.wake    = next_s.pb_sfr[PB_WAKE] & pb_smp[PB_WAKE];
        next_s.irq1    = next_s.pb_sfr[PB_IRQ1] & pb_smp[PB_IRQ1];
        next_s.irq_b4  = next_s.pb_sfr[PB_SIG]
                       & (cmp_next ? cmp_smp : pb_smp[PB_SIG]);
    end

    always_ff @(posedge clk_i) begin
        s <= next_s;
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign dat_o             = s.dat;
    assign ack_o             = s.ack;
    assign pa_pin_o          = s.pa_drv;
    assign pa_pin_oe_o       = s.pa_oe;
    assign pa_schmitt_en_o   = s.pa_sch;
    assign pb_pin_o          = s.pb_drv;
    assign pb_pin_oe_o       = s.pb_oe;
    assign pb_schmitt_en_o   = s.pb_sch;
    assign cmp_enable_o      = s.cmp_en;
    assign stop_wake_event_o = s.wake;
    assign ext_irq1_o        = s.irq1;
    assign ext_irq_b4_o      = s.irq_b4;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    logic pa_sch_all;
    assign pa_sch_all = &pa_schmitt_en_o;

    a_reset_dir_clear: assert property (@(posedge clk_i)
        rst_i |=> (s.pa_dir == 8'h00) && (s.pb_dir == 5'h00) && pa_sch_all)
        else $error("direction not cleared by reset");

    a_reset_sfr_clear: assert property (@(posedge clk_i)
        rst_i |=> (s.pa_sfr == 8'h00) && (s.pb_sfr == 5'h00) && !cmp_enable_o)
        else $error("special function not cleared by reset");

    a_reset_out_keep: assert property (@(posedge clk_i)
        rst_i |=> (s.pa_out === $past(s.pa_out))
              && (s.pb_out === $past(s.pb_out)))
        else $error("output register changed by reset");

    // Synchronizer has no reset: only check once it has been filled
    a_reset_in_load: assert property (@(posedge clk_i)
        rst_i && $past(rst_i) && $past(rst_i, 2)
        |=> (s.pa_in == $past(pa_smp)) && (s.pb_in == $past(pb_smp)))
        else $error("input register not loaded at reset");

    a_input_sample: assert property (@(posedge clk_i) disable iff (rst_i)
        !bus_wr |=> ((s.pa_in ^ $past(pa_smp)) & ~$past(s.pa_dir)) == 8'h00)
        else $error("input bit does not follow synchronized pin");

    a_input_hold: assert property (@(posedge clk_i) disable iff (rst_i)
        !bus_wr ##1 !rst_i |-> ((s.pb_in ^ $past(s.pb_in)) & $past(s.pb_dir))
                               == 5'h00)
        else $error("input bit of output pin changed");

    a_write_overrun: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_wr && bus_sel.hit && bus_sel.idx == 3'h0 && s.pa_dir == 8'h00
        |=> s.pa_in == $past(dat_i[PA_W-1:0])
        ##1 (rst_i || bus_wr || s.pa_in == $past(pa_smp)))
        else $error("input write not replaced by sample");

    a_out_write: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_wr && bus_sel.hit && bus_sel.idx == 3'h1
        |=> s.pa_out == $past(dat_i[PA_W-1:0]))
        else $error("output register write lost");

    a_pin_drive: assert property (@(posedge clk_i) disable iff (rst_i)
        (pa_pin_oe_o == (s.pa_dir & ~(s.pa_sfr & s.pa_out)))
        && (pa_pin_o == (s.pa_out & s.pa_dir & ~s.pa_sfr))
        && (pa_schmitt_en_o == ~s.pa_dir))
        else $error("first port pin drive wrong");

    a_tout_toggle: assert property (@(posedge clk_i) disable iff (rst_i)
        t0_end_count_i && s.pb_sfr[PB_TOUT] && s.pb_dir[PB_TOUT] && !bus_wr
        |=> (s.tout != $past(s.tout)) && (pb_pin_o[PB_TOUT] == s.tout))
        else $error("timer output did not toggle");

    a_comp_route: assert property (@(posedge clk_i) disable iff (rst_i)
        cmp_on && !s.pb_dir[PB_SIG] && !bus_wr
        |=> s.pb_in[PB_SIG] == $past(cmp_smp))
        else $error("comparator result not in input bit");

    a_irq_source: assert property (@(posedge clk_i) disable iff (rst_i)
        cmp_on && s.pb_sfr == $past(s.pb_sfr)
        |-> ext_irq_b4_o == $past(cmp_smp))
        else $error("bit 4 interrupt not from comparator");

    a_wb_ack: assert property (@(posedge clk_i) disable iff (rst_i)
        bus_req && !ack_o |=> ack_o ##1 !ack_o)
        else $error("bus ack not a single cycle after one wait");

    c_open_drain: cover property (@(posedge clk_i) disable iff (rst_i)
        |(s.pa_dir & s.pa_sfr & ~s.pa_out));
    c_tout_run: cover property (@(posedge clk_i) disable iff (rst_i)
        t0_end_count_i && s.pb_sfr[PB_TOUT] && s.pb_dir[PB_TOUT]);
    c_comp_irq: cover property (@(posedge clk_i) disable iff (rst_i)
        cmp_enable_o && ext_irq_b4_o);
    c_in_write: cover property (@(posedge clk_i) disable iff (rst_i)
        bus_wr && bus_sel.hit && bus_sel.idx == 3'h4);

endmodule
`default_nettype wire

// file: bench/dbio_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
module dbio_pin_model import dbio_pkg::*; (
    input  wire logic [PA_W-1:0] pa_out_i,
    input  wire logic [PA_W-1:0] pa_oe_i,
    input  wire logic [PA_W-1:0] pa_ext_en_i,
    input  wire logic [PA_W-1:0] pa_ext_val_i,
    output logic      [PA_W-1:0] pa_level_o,
    input  wire logic [PB_W-1:0] pb_out_i,
    input  wire logic [PB_W-1:0] pb_oe_i,
    input  wire logic [PB_W-1:0] pb_ext_en_i,
    input  wire logic [PB_W-1:0] pb_ext_val_i,
    output logic      [PB_W-1:0] pb_level_o,
    input  wire logic [11:0]     sig_mv_i,
    input  wire logic [11:0]     ref_mv_i,
    output logic                 cmp_result_o
);
    // ------------------------------------------------------------
    // Pin levels
    // ------------------------------------------------------------
    // An external driver overpowers the port; released lines pull up
    assign pa_level_o = (pa_ext_en_i & pa_ext_val_i)
                      | (~pa_ext_en_i & ((pa_oe_i & pa_out_i) | ~pa_oe_i));
    assign pb_level_o = (pb_ext_en_i & pb_ext_val_i)
                      | (~pb_ext_en_i & ((pb_oe_i & pb_out_i) | ~pb_oe_i));
    // ------------------------------------------------------------
    // Comparator
    // ------------------------------------------------------------
    assign cmp_result_o = (sig_mv_i > ref_mv_i);
endmodule
`default_nettype wire

// file: bench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
    import dbio_pkg::*;
    logic             clk_i, rst_i, cyc, stb, we, t0;
    logic [ADR_W-1:0] adr;
    logic [DAT_W-1:0] dat;
    logic [3:0]       sel;
    logic [PA_W-1:0]  pa_en, pa_val;
    logic [PB_W-1:0]  pb_en, pb_val;
    logic [11:0]      sig_mv, ref_mv;
    wire  [DAT_W-1:0] dat_o;
    wire              ack_o, cmp_res, cmp_enable_o, stop_wake_event_o;
    wire              ext_irq1_o, ext_irq_b4_o;
    wire  [PA_W-1:0]  pa_lvl, pa_pin_o, pa_pin_oe_o, pa_schmitt_en_o;
    wire  [PB_W-1:0]  pb_lvl, pb_pin_o, pb_pin_oe_o, pb_schmitt_en_o;
    int               err_total = 0;
    int               checks = 0;
    int               cycles = 0;

    dbio_top u_dbio_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
        .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(dat), .sel_i(sel),
        .dat_o(dat_o), .ack_o(ack_o), .pa_pin_i(pa_lvl),
        .pa_pin_o(pa_pin_o), .pa_pin_oe_o(pa_pin_oe_o),
        .pa_schmitt_en_o(pa_schmitt_en_o), .pb_pin_i(pb_lvl),
        .pb_pin_o(pb_pin_o), .pb_pin_oe_o(pb_pin_oe_o),
        .pb_schmitt_en_o(pb_schmitt_en_o), .cmp_result_i(cmp_res),
        .cmp_enable_o(cmp_enable_o), .t0_end_count_i(t0),
        .stop_wake_event_o(stop_wake_event_o), .ext_irq1_o(ext_irq1_o),
        .ext_irq_b4_o(ext_irq_b4_o));

    dbio_pin_model u_dbio_pin_model (.pa_out_i(pa_pin_o),
        .pa_oe_i(pa_pin_oe_o), .pa_ext_en_i(pa_en), .pa_ext_val_i(pa_val),
        .pa_level_o(pa_lvl), .pb_out_i(pb_pin_o), .pb_oe_i(pb_pin_oe_o),
        .pb_ext_en_i(pb_en), .pb_ext_val_i(pb_val), .pb_level_o(pb_lvl),
        .sig_mv_i(sig_mv), .ref_mv_i(ref_mv), .cmp_result_o(cmp_res));

    // ------------------------------------------------------------
    // Clock, timeout and closing report
    // ------------------------------------------------------------
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end

    task automatic end_of_test;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 3000) begin
            err_total++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------
    // Bus cycles and comparisons
    // ------------------------------------------------------------
    task automatic check(input string name, input logic [31:0] seen,
                         input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wb_xfer(input logic w, input logic [9:0] idx,
                           input logic [7:0] d, output logic [7:0] q);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we  <= w;
        adr <= {idx, 2'b00};
        dat <= {24'h000000, d};
        sel <= 4'hf;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        q = dat_o[7:0];
        if (ack_o !== 1'b1) err_total++;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [7:0] d);
        logic [7:0] q;
        wb_xfer(1'b1, idx, d, q);
    endtask

    task automatic rd_chk(input string name, input logic [9:0] idx,
                          input logic [7:0] exp);
        logic [7:0] q;
        wb_xfer(1'b0, idx, 8'h00, q);
        check(name, {24'h000000, q}, {24'h000000, exp});
    endtask

    // Pins need two sync stages plus the register and the event flop
    task automatic settle;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
    endtask

    task automatic pulse_rst;
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
    endtask

    // ------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------
    initial begin
        rst_i  = 1'b1;
        cyc    = 1'b0;
        stb    = 1'b0;
        we     = 1'b0;
        adr    = 12'h000;
        dat    = 32'h00000000;
        sel    = 4'h0;
        t0     = 1'b0;
        pa_en  = 8'hff;
        pa_val = 8'h5a;
        pb_en  = 5'h1f;
        pb_val = 5'h0a;
        sig_mv = 12'h064;
        ref_mv = 12'h0c8;
        pulse_rst();
        settle();
        check("pa_oe", pa_pin_oe_o, 8'h00);
        check("pa_schmitt", pa_schmitt_en_o, 8'hff);
        rd_chk("pa_dir", IDX_PA_DIR, PA_DIR_RST);
        rd_chk("pb_dir", IDX_PB_DIR, PB_DIR_RST);
        rd_chk("pa_sfr", IDX_PA_SFR, PA_SFR_RST);
        rd_chk("pb_sfr", IDX_PB_SFR, PB_SFR_RST);
        rd_chk("pa_in", IDX_PA_IN, 8'h5a);
        rd_chk("pb_in", IDX_PB_IN, 8'h0a);
        rd_chk("unmapped", 10'h0d8, 8'h00);
        wr(IDX_PA_IN, 8'h3c);
        rd_chk("pa_in_ovr", IDX_PA_IN, 8'h5a);
        wr(IDX_PA_OUT, 8'ha5);
        wr(IDX_PA_DIR, 8'hf0);
        settle();
        check("pa_o_mix", pa_pin_o, 8'ha0);
        check("pa_oe_mix", pa_pin_oe_o, 8'hf0);
        wr(IDX_PA_DIR, 8'hff);
        wr(IDX_PA_IN, 8'h3c);
        settle();
        check("pa_o", pa_pin_o, 8'ha5);
        check("pa_schmitt_off", pa_schmitt_en_o, 8'h00);
        rd_chk("pa_in_keep", IDX_PA_IN, 8'h3c);
        rd_chk("pa_out_rd", IDX_PA_OUT, 8'ha5);
        wr(IDX_PA_SFR, 8'hff);
        settle();
        check("pa_od_oe", pa_pin_oe_o, 8'h5a);
        check("pa_od_o", pa_pin_o, 8'h00);
        wr(IDX_PA_SFR, 8'h00);
        settle();
        check("pa_pp_oe", pa_pin_oe_o, 8'hff);
        pb_en <= 5'h00;
        wr(IDX_PB_OUT, 8'h17);
        wr(IDX_PB_DIR, 8'h1f);
        settle();
        check("pb_o", pb_pin_o, 5'h17);
        check("pb_oe", pb_pin_oe_o, 5'h1f);
        check("pb_schmitt_off", pb_schmitt_en_o, 5'h00);
        wr(IDX_PB_SFR, 8'h02);
        settle();
        check("pb_tout0", pb_pin_o, 5'h15);
        for (int i = 0; i < 2; i++) begin
            @(posedge clk_i);
            t0 <= 1'b1;
            @(posedge clk_i);
            t0 <= 1'b0;
            settle();
            check("pb_tout", pb_pin_o, (i == 0) ? 5'h17 : 5'h15);
        end
        wr(IDX_PB_SFR, 8'h00);
        wr(IDX_PB_DIR, 8'h00);
        pb_en  <= 5'h1f;
        pb_val <= 5'h15;
        wr(IDX_PB_SFR, 8'h05);
        settle();
        check("wake", stop_wake_event_o, 1'b1);
        check("irq1", ext_irq1_o, 1'b1);
        check("irq_b4_off", ext_irq_b4_o, 1'b0);
        wr(IDX_PB_SFR, 8'h10);
        settle();
        check("irq_b4", ext_irq_b4_o, 1'b1);
        check("wake_off", stop_wake_event_o, 1'b0);
        wr(IDX_PB_SFR, 8'h18);
        settle();
        check("cmp_en", cmp_enable_o, 1'b1);
        check("irq_cmp_lo", ext_irq_b4_o, 1'b0);
        rd_chk("pb_in_cmp_lo", IDX_PB_IN, 8'h05);
        @(posedge clk_i);
        sig_mv <= 12'h12c;
        settle();
        check("irq_cmp_hi", ext_irq_b4_o, 1'b1);
        rd_chk("pb_in_cmp_hi", IDX_PB_IN, 8'h15);
        pulse_rst();
        settle();
        rd_chk("pa_out_kept", IDX_PA_OUT, 8'ha5);
        rd_chk("pb_out_kept", IDX_PB_OUT, 8'h17);
        rd_chk("pb_sfr_clr", IDX_PB_SFR, PB_SFR_RST);
        check("cmp_off", cmp_enable_o, 1'b0);
        check("pb_oe_clr", pb_pin_oe_o, 5'h00);
        check("pb_schmitt_on", pb_schmitt_en_o, 5'h1f);
        end_of_test();
    end
endmodule
`default_nettype wire
